// File: hdl/memory_link_mode_fsm.sv
/*
  operating-mode state machine of the responding device with Avalon-MM
  register slave; assumes link pins are asynchronous and are synchronised
  here, and an Avalon master that holds requests until waitrequest is low
*/
// Contract
// - nine frame states forming three modes
// - power-up enters reset, registers take defaults
// - power-up passes decision state into standby
// - ones count at 272 forces reset
// - a 00 packet clears ones, leaving reset
// - zeros count at 10 enters standby
// - one 11 packet leaves standby for active
// - runs of 1 to 4 wake device
// - active within 4 cycles of first packet
// - idle hold window ends in standby
// - framing starts active, ends in standby
// - reset holds under 11, exits on 00
// - read data at programmed latency after request
// - read minus ack latency fixed everywhere
// - 00 counts zeros, 11 counts ones
`timescale 1ns/100ps
`include "memory_link_mode_cfg.svh"
module memory_link_mode_fsm
  import memory_link_mode_pkg::*;
#(
  parameter int ONES_W = 9,
  parameter int RELOCK_CYCLES =
    (`CLOCK_RELOCK_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire link_pins_s linkPins,
  output logic ackValid,
  output logic [1:0] ackCode,
  output logic readDataStart,
  output logic activeMode
);
  localparam logic [1:0] ACK_OKAY = 2'h1;
  localparam logic [1:0] ACK_NACK = 2'h2;
  localparam logic [ONES_W-1:0] ONES_MAX = '1;

  // saturating increments of the run counters
  function automatic logic [ONES_W-1:0] incOnes(logic [ONES_W-1:0] v);
    return (v == ONES_MAX) ? v : v + 1'b1;
  endfunction : incOnes
  function automatic logic [3:0] incZeros(logic [3:0] v);
    return (v == 4'hF) ? v : v + 4'h1;
  endfunction : incZeros

  // two-flop synchroniser for every link pin
  link_pins_s pinsMeta, pins;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinsMeta <= '0;
      pins <= '0;
    end else begin
      pinsMeta <= linkPins;
      pins <= pinsMeta;
    end
  end

  // frame state, run counters, transaction counter
  frame_e state, next_state;
  logic [ONES_W-1:0] ones, next_ones;
  logic [3:0] zeros, next_zeros;
  logic [7:0] txCnt, next_txCnt;
  logic isRead, next_isRead;
  logic [7:0] reqId, next_reqId;
  logic okRead, next_okRead;
  logic [1:0] next_ackCode;
  logic next_ackValid, next_readDataStart;
  logic [4:0] readLat, next_readLat;
  logic [7:0] devId, next_devId;
  logic busy, next_busy, powerDown, next_powerDown;
  logic [7:0] ackLat, replyEnd;

  // ack latency leads read latency by a fixed gap
  assign ackLat = 8'(readLat) - 8'(`READ_ACK_GAP);
  assign replyEnd = okRead ? 8'(readLat) : ackLat + 8'(`ACK_WINDOW);

  // next state of the frame machine and counters
  always_comb begin
    next_state = state;
    next_txCnt = txCnt + 8'h1;
    next_isRead = isRead;
    next_reqId = reqId;
    next_okRead = okRead;
    next_ackValid = 1'b0;
    next_ackCode = 2'h0;
    next_readDataStart = 1'b0;
    if (pins.linkEnable) begin
      next_ones = incOnes(ones);
      next_zeros = 4'h0;
    end else begin
      next_ones = '0;
      next_zeros = incZeros(zeros);
    end
    unique case (state)
      init_hold_state: begin
        if (next_ones < ONES_W'(`STANDBY_TO_ACTIVE_MIN))
          next_state = decision_state;
      end
      idle_wait_state: begin
        if (next_ones >= ONES_W'(`STANDBY_TO_ACTIVE_MIN))
          next_state = decision_state;
      end
      decision_state: begin
        if (pins.reqStart) begin
          next_state = frame_state;
          next_txCnt = 8'h0;
          next_isRead = pins.reqRead;
          next_reqId = pins.reqDevId; // id gone once the packet ends
        end else if (next_zeros >= 4'(`MODE_HOLD_MAX))
          next_state = idle_wait_state;
      end
      frame_state: begin
        if (txCnt == 8'(`REQ_CYCLES - 1)) begin
          next_state = match_check_state;
          next_txCnt = 8'h0;
        end
      end
      match_check_state: begin
        next_okRead = 1'b0;
        if (reqId == devId)
          next_state = device_state;
        else
          next_state = reply_window_state; // passive, no ack
      end
      device_state: begin
        next_state = busy ? refuse_state : okay_state;
      end
      okay_state, refuse_state: begin
        if (txCnt == ackLat) begin
          next_ackValid = 1'b1;
          next_ackCode = (state == okay_state) ? ACK_OKAY : ACK_NACK;
          next_okRead = (state == okay_state) && isRead;
          next_state = reply_window_state;
        end
      end
      reply_window_state: begin
        if (okRead && txCnt == 8'(readLat))
          next_readDataStart = 1'b1;
        if (txCnt >= replyEnd)
          next_state = idle_wait_state;
      end
    endcase
    if (state != init_hold_state &&
        next_ones >= ONES_W'(`ACTIVE_TO_RESET_MIN))
      next_state = init_hold_state;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= init_hold_state;
      ones <= '0;
      zeros <= 4'h0;
      txCnt <= 8'h0;
      isRead <= 1'b0;
      reqId <= 8'h00;
      okRead <= 1'b0;
      ackValid <= 1'b0;
      ackCode <= 2'h0;
      readDataStart <= 1'b0;
      activeMode <= 1'b0;
    end else begin
      state <= next_state;
      ones <= next_ones;
      zeros <= next_zeros;
      txCnt <= next_txCnt;
      isRead <= next_isRead;
      reqId <= next_reqId;
      okRead <= next_okRead;
      ackValid <= next_ackValid;
      ackCode <= next_ackCode;
      readDataStart <= next_readDataStart;
      activeMode <= next_state != init_hold_state &&
        next_state != idle_wait_state;
    end
  end

  // relock counter, started on each exit from reset mode
  logic [15:0] lockCnt, next_lockCnt;
  always_comb begin
    next_lockCnt = lockCnt;
    if (state == init_hold_state)
      next_lockCnt = 16'(RELOCK_CYCLES);
    else if (lockCnt != 16'h0)
      next_lockCnt = lockCnt - 16'h1;
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn)
      lockCnt <= 16'h0;
    else
      lockCnt <= next_lockCnt;
  end

  // Avalon slave: one wait cycle, then the access completes
  logic next_waitrequest;
  logic [31:0] next_readdata;
  logic take;
  assign take = (read || write) && !waitrequest;
  always_comb begin
    next_waitrequest = !((read || write) && waitrequest);
    next_readdata = readdata;
    next_readLat = readLat;
    next_devId = devId;
    next_busy = busy;
    next_powerDown = powerDown;
    if (read && waitrequest) begin
      next_readdata = 32'h0000_0000;
      unique case (address)
        `OFF_SPACING: next_readdata[`POS_POWER_DOWN] = powerDown;
        `OFF_TIMING: next_readdata[4:0] = readLat;
        `OFF_CTRL: begin
          next_readdata[7:0] = devId;
          next_readdata[`POS_BUSY] = busy;
        end
        `OFF_STATUS: begin
          next_readdata[3:0] = state;
          next_readdata[`POS_LOCKED] = lockCnt == 16'h0;
          next_readdata[`POS_ZEROS+:4] = zeros;
          next_readdata[`POS_ONES+:ONES_W] = ones;
        end
        default: next_readdata = 32'h0000_0000;
      endcase
    end
    if (write && take) begin
      unique case (address)
        `OFF_SPACING:
          next_powerDown = writedata[`POS_POWER_DOWN];
        `OFF_TIMING: next_readLat = writedata[4:0];
        `OFF_CTRL: begin
          next_devId = writedata[7:0];
          next_busy = writedata[`POS_BUSY];
        end
        default: next_busy = busy;
      endcase
    end
    if (state == init_hold_state) begin
      next_readLat = `RST_READ_LAT;
      next_devId = `RST_DEV_ID;
      next_busy = 1'b0;
      next_powerDown = 1'b0;
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
      readLat <= `RST_READ_LAT;
      devId <= `RST_DEV_ID;
      busy <= 1'b0;
      powerDown <= 1'b0;
    end else begin
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
      readLat <= next_readLat;
      devId <= next_devId;
      busy <= next_busy;
      powerDown <= next_powerDown;
    end
  end

  // checks
  a_wake_offset: assert property (@(posedge mclk) disable iff (!resetn)
    state == idle_wait_state && pins.linkEnable |=> activeMode)
    else $error("standby not left after 11 packet");
  a_reset_entry: assert property (@(posedge mclk) disable iff (!resetn)
    state != init_hold_state && pins.linkEnable &&
    ones == ONES_W'(`ACTIVE_TO_RESET_MIN - 1) |=> state == init_hold_state)
    else $error("reset not entered at ones threshold");
  a_reset_exit: assert property (@(posedge mclk) disable iff (!resetn)
    state == init_hold_state && !pins.linkEnable |=> state == decision_state)
    else $error("reset not left on 00 packet");
  a_reset_hold: assert property (@(posedge mclk) disable iff (!resetn)
    state == init_hold_state && pins.linkEnable |=> state == init_hold_state)
    else $error("reset left under 11 packets");
  a_hold_window: assert property (@(posedge mclk) disable iff (!resetn)
    state == decision_state && !pins.reqStart && !pins.linkEnable &&
    zeros == 4'(`MODE_HOLD_MAX - 1) |=> state == idle_wait_state)
    else $error("hold window not closed at ten");
  a_ones_sat: assert property (@(posedge mclk) disable iff (!resetn)
    ones == ONES_MAX && pins.linkEnable |=> ones == ONES_MAX)
    else $error("ones counter wrapped");
  a_run_clear: assert property (@(posedge mclk) disable iff (!resetn)
    pins.linkEnable |=> zeros == 4'h0 && ones != '0)
    else $error("11 packet did not move counters");
  a_read_lat: assert property (@(posedge mclk) disable iff (!resetn)
    ackValid && ackCode == ACK_OKAY && okRead |->
    ##(`READ_ACK_GAP) readDataStart)
    else $error("read data not at read latency");
  a_end_standby: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(activeMode) |-> state == idle_wait_state ||
    state == init_hold_state)
    else $error("active mode left to wrong state");
  c_wake: cover property (@(posedge mclk) disable iff (!resetn)
    state == idle_wait_state ##1 state == decision_state);
  c_okay_read: cover property (@(posedge mclk) disable iff (!resetn)
    readDataStart);
  c_nack: cover property (@(posedge mclk) disable iff (!resetn)
    ackValid && ackCode == ACK_NACK);
  c_reset: cover property (@(posedge mclk) disable iff (!resetn)
    state == decision_state ##1 state == init_hold_state);
endmodule : memory_link_mode_fsm

// File: hdl/memory_link_mode_cfg.svh
/*
  offsets, field positions, reset values and timing counts of the
  operating-mode block; assumes a 100 MHz mclk
*/
`ifndef MEMORY_LINK_MODE_CFG_SVH
`define MEMORY_LINK_MODE_CFG_SVH
// register byte offsets
`define OFF_SPACING 4'h0
`define OFF_TIMING 4'h4
`define OFF_CTRL 4'h8
`define OFF_STATUS 4'hC
// field positions
`define POS_POWER_DOWN 2
`define POS_BUSY 8
`define POS_LOCKED 4
`define POS_ZEROS 12
`define POS_ONES 16
// reset values
`define RST_READ_LAT 5'h08
`define RST_DEV_ID 8'h00
// mode counts, in packets or cycles
`define STANDBY_TO_ACTIVE_MIN 1
`define ACTIVE_TO_RESET_MIN 272
`define MODE_HOLD_MAX 10
`define MODE_OFFSET_MIN 4
// framing counts
`define REQ_CYCLES 4
`define ACK_WINDOW 4
`define READ_ACK_GAP 2
// relock time in ns and clock period in ns
`define CLOCK_RELOCK_NS 10000
`define MCLK_PERIOD_NS 10
`endif

// File: hdl/memory_link_mode_pkg.sv
/*
  types of the operating-mode block: frame states and link pin group;
  assumes memory_link_mode_cfg.svh for all numbers
*/
package memory_link_mode_pkg;
  // frame state machine, nine states
  typedef enum logic [3:0] {
    init_hold_state = 4'h0,
    idle_wait_state = 4'h1,
    decision_state = 4'h2,
    frame_state = 4'h3,
    match_check_state = 4'h4,
    device_state = 4'h5,
    okay_state = 4'h6,
    refuse_state = 4'h7,
    reply_window_state = 4'h8
  } frame_e;
  // pins from the initiator, all asynchronous to mclk
  typedef struct packed {
    logic linkEnable;
    logic reqStart;
    logic reqRead;
    logic [7:0] reqDevId;
  } link_pins_s;
endpackage : memory_link_mode_pkg

// File: bench/memory_link_initiator.sv
/*
  model of the initiating controller: sends mode packets and requests
  assumes mclk from the bench; the bench calls its tasks after an edge
*/
`timescale 1ns/100ps
`include "memory_link_mode_cfg.svh"
module memory_link_initiator
  import memory_link_mode_pkg::*;
(
  input wire logic mclk,
  output link_pins_s linkPins
);
  // enable idles low between packets
  initial linkPins = '0;
  // run of n packets of 11, then back to 00; never 01 or 10
  task automatic ones(input int n);
    linkPins.linkEnable <= 1'b1;
    repeat (n) @(posedge mclk);
    linkPins.linkEnable <= 1'b0;
  endtask : ones
  // request packet; bench starts it only once active and relocked
  task automatic request(input logic rd, input logic [7:0] id);
    linkPins.reqStart <= 1'b1;
    linkPins.reqRead <= rd;
    linkPins.reqDevId <= id;
    @(posedge mclk);
    linkPins.reqStart <= 1'b0;
    repeat (`REQ_CYCLES - 1) @(posedge mclk);
    linkPins.reqDevId <= ~id; // released: show stale inverse
    linkPins.reqRead <= ~rd;
  endtask : request
endmodule : memory_link_initiator

// File: bench/memory_link_mode_fsm_tb_top.sv
/*
  self-checking bench of the operating-mode block
  assumes the initiator model and a 100 MHz mclk
*/
`timescale 1ns/100ps
`include "memory_link_mode_cfg.svh"
module memory_link_mode_fsm_tb_top
  import memory_link_mode_pkg::*;
;
  logic mclk;
  logic resetn = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic waitrequest;
  link_pins_s linkPins;
  logic ackValid;
  logic [1:0] ackCode;
  logic readDataStart;
  logic activeMode;
  int miscompares = 0;
  int check_count = 0;
  memory_link_mode_fsm #(.RELOCK_CYCLES(20)) i_memory_link_mode_fsm (
    .mclk(mclk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .linkPins(linkPins), .ackValid(ackValid),
    .ackCode(ackCode), .readDataStart(readDataStart),
    .activeMode(activeMode));
  memory_link_initiator i_memory_link_initiator (
    .mclk(mclk), .linkPins(linkPins));
  // 10 ns clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  // bounded wait for a level; a hard wait that expires ends the run
  task automatic wait_on(ref logic s, input logic v, input int lim,
                         input bit must, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
    if (must && n == lim) begin
      miscompares++;
      tally_and_finish;
    end
  endtask : wait_on
  // one Avalon access, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge mclk);
      k++;
    end while (waitrequest !== 1'b0 && k < 20);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      miscompares++;
      tally_and_finish;
    end
    @(posedge mclk);
  endtask : av
  task automatic t_power_up;
    logic [31:0] q;
    repeat (30) @(posedge mclk);
    av(1'b0, `OFF_STATUS, '0, q);
    chk("state", q[3:0], 4'h1);
    chk("zeros", q[15:12], 4'hF);
    av(1'b0, `OFF_TIMING, '0, q);
    chk("readlat", q[4:0], 5'h08);
    av(1'b0, `OFF_CTRL, '0, q);
    chk("ctrl", q, 32'h0000_0000);
    av(1'b0, 4'h2, '0, q);
    chk("unmapped", q, 32'h0000_0000);
    av(1'b1, `OFF_SPACING, 32'h0000_0000, q);
  endtask : t_power_up
  task automatic t_wake;
    logic [31:0] q;
    int n;
    for (int k = 1; k <= 4; k++) begin
      fork
        i_memory_link_initiator.ones(k);
        wait_on(activeMode, 1'b1, 8, 1'b1, n);
      join
      chk("offset", n <= 4, 1'h1);
      wait_on(activeMode, 1'b0, 30, 1'b1, n);
      av(1'b0, `OFF_STATUS, '0, q);
      chk("standby", q[3:0], 4'h1);
    end
  endtask : t_wake
  task automatic t_txn(input logic [4:0] lat, input logic busy,
                       input logic [7:0] id, input logic [1:0] code,
                       input logic rd, output int tot);
    logic [31:0] q;
    int a;
    int r;
    av(1'b1, `OFF_TIMING, {27'h0, lat}, q);
    av(1'b1, `OFF_CTRL, {23'h0, busy, 8'h5A}, q);
    i_memory_link_initiator.ones(1);
    repeat (3) @(posedge mclk);
    chk("framing", activeMode, 1'h1);
    i_memory_link_initiator.request(rd, id);
    wait_on(ackValid, 1'b1, 30, 1'b0, a);
    chk("ack", (a < 30) ? ackCode : 2'h0, code);
    wait_on(readDataStart, 1'b1, 8, 1'b0, r);
    chk("gap", r, (code == 2'h1 && rd) ? 2 : 8);
    tot = a + r;
    wait_on(activeMode, 1'b0, 30, 1'b1, r);
    av(1'b0, `OFF_STATUS, '0, q);
    chk("after", q[3:0], 4'h1);
  endtask : t_txn
  task automatic t_mode_reset;
    logic [31:0] q;
    int n;
    av(1'b1, `OFF_TIMING, 32'h0000_0005, q);
    fork
      i_memory_link_initiator.ones(520);
      begin
        repeat (290) @(posedge mclk);
        av(1'b0, `OFF_STATUS, '0, q);
        chk("reset", q[3:0], 4'h0);
        chk("resetact", activeMode, 1'h0);
        repeat (222) @(posedge mclk);
        av(1'b0, `OFF_STATUS, '0, q);
        chk("onessat", q[24:16], 9'h1FF);
        chk("satstate", q[3:0], 4'h0);
      end
    join
    wait_on(activeMode, 1'b1, 6, 1'b1, n);
    // keep-alive bursts while the clock relocks
    repeat (4) begin
      i_memory_link_initiator.ones(2);
      repeat (6) @(posedge mclk);
      chk("keep", activeMode, 1'h1);
    end
    av(1'b0, `OFF_STATUS, '0, q);
    chk("locked", q[4], 1'h1);
    av(1'b0, `OFF_TIMING, '0, q);
    chk("default", q[4:0], 5'h08);
  endtask : t_mode_reset
  // main sequence
  initial begin
    int t8;
    int t12;
    int t;
    repeat (3) @(posedge mclk);
    chk("waitreq", waitrequest, 1'h1);
    resetn <= 1'b1;
    t_power_up;
    t_wake;
    t_txn(5'h08, 1'b0, 8'h5A, 2'h1, 1'b1, t8);
    t_txn(5'h0C, 1'b0, 8'h5A, 2'h1, 1'b1, t12);
    chk("latency", t12 - t8, 4);
    t_txn(5'h08, 1'b0, 8'h5A, 2'h1, 1'b0, t);
    t_txn(5'h08, 1'b1, 8'h5A, 2'h2, 1'b1, t);
    t_txn(5'h08, 1'b0, 8'h33, 2'h0, 1'b1, t);
    t_mode_reset;
    tally_and_finish;
  end
endmodule : memory_link_mode_fsm_tb_top
